// ===== rtl/pie_pkg.sv
// package for the peripheral interrupt enable and flag block
// shared register offsets, field positions, masks and reset values
package pie_pkg;
  localparam int          DATA_W        = 8;
  localparam int          PADDR_W       = 8;
  // byte offsets on the apb bus
  localparam logic [7:0]  OFF_ENABLE_A  = 8'h00;
  localparam logic [7:0]  OFF_ENABLE_B  = 8'h04;
  localparam logic [7:0]  OFF_FLAGS_A   = 8'h08;
  localparam logic [7:0]  OFF_FLAGS_B   = 8'h0c;
  localparam logic [7:0]  OFF_INT_CTRL  = 8'h10;
  localparam logic [7:0]  OFF_EVT_STAT  = 8'h14;
  localparam logic [7:0]  OFF_EVT_EN    = 8'h18;
  localparam logic [7:0]  OFF_EVT_CLR   = 8'h1c;
  // bit positions, first register pair
  localparam int          BIT_T1_GATE   = 7;
  localparam int          BIT_CONV_DONE = 6;
  localparam int          BIT_LIMIT_TMR = 2;
  localparam int          BIT_TIMER2    = 1;
  localparam int          BIT_TIMER1    = 0;
  // bit positions, second register pair
  localparam int          BIT_CMP2      = 5;
  localparam int          BIT_CMP1      = 4;
  localparam int          BIT_WAVE_GEN  = 2;
  localparam int          BIT_CAP_CMP   = 0;
  // interrupt control register bits
  localparam int          BIT_GLOBAL_EN = 7;
  localparam int          BIT_GROUP_EN  = 6;
  // implemented bits
  localparam logic [7:0]  MASK_A        = 8'hc7;
  localparam logic [7:0]  MASK_B        = 8'h35;
  localparam logic [7:0]  MASK_CTRL     = 8'hc0;
  localparam logic [7:0]  MASK_EVT      = 8'h03;
  localparam logic [7:0]  RESET_VAL     = 8'h00;
  localparam logic [31:0] READ_ZERO     = 32'h0000_0000;
  // capture/compare unit modes
  localparam logic [1:0]  CCP_CAPTURE   = 2'h1;
  localparam logic [1:0]  CCP_COMPARE   = 2'h2;
  localparam logic [1:0]  CCP_PWM       = 2'h3;
endpackage

// ===== rtl/flag_bank.sv
// sticky flag bank with software clear, set wins over clear
// events are single-cycle pulses on ref_clk
`timescale 1ns/1ns
module flag_bank
  import pie_pkg::*;
#(
  parameter int W = DATA_W
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] set_evt,
  input  wire logic [W-1:0] clr,
  input  wire logic [W-1:0] impl_mask,
  output logic      [W-1:0] flags
);
  typedef struct packed {
    logic [W-1:0] flags;
  } bank_state_t;

  bank_state_t st_r;
  bank_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    for (int i = 0; i < W; i++) begin
      if (set_evt[i] && impl_mask[i]) begin
        st_nxt.flags[i] = 1'b1;
      end else if (clr[i]) begin
        st_nxt.flags[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign flags = st_r.flags;

  a_set_sticks: assert property (@(posedge ref_clk) disable iff (rst)
    (set_evt & impl_mask) != '0
    |=> ((flags & $past(set_evt & impl_mask)) == $past(set_evt & impl_mask)))
    else $error("event did not set its flag");
endmodule

// ===== rtl/periph_irq.sv
// peripheral interrupt enables, request flags and processor request
// apb slave on ref_clk; event inputs are ref_clk pulses or levels from peripherals
`timescale 1ns/1ns
// Summary of operation
// - enable bit 7 gates timer1 gate request
// - enable bit 6 gates conversion done request
// - enable bit 2 gates limit timer request
// - enable bit 1 gates timer2 match request
// - enable bit 0 gates rollover; 5-3 read zero
// - group enable must be set for any request except event_irq
// - second enable register bits 5,4,2,0 only
// - flags set regardless of any enable
// - flag bit 6 set on conversion done
// - flag bit 2 limit match, sticky
// - flag bit 1 timer2 match, sticky
// - flag bit 0 rollover sticky; 5-3 zero
// - comparator output changes set bits 5,4
// - shutdown sets second flag bit 2
// - capture or compare sets bit 0
module periph_irq
  import pie_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               rst,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [PADDR_W-1:0] paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               timer1_gate_evt,
  input  wire logic               conversion_done_evt,
  input  wire logic               limit_timer_match_evt,
  input  wire logic               timer2_match_evt,
  input  wire logic               timer1_rollover_evt,
  input  wire logic               comparator2_output,
  input  wire logic               comparator1_output,
  input  wire logic               waveform_gen_shutdown_evt,
  input  wire logic [1:0]         ccp_mode,
  input  wire logic               ccp_capture_evt,
  input  wire logic               ccp_compare_evt,
  output logic                    periph_irq_req,
  output logic                    cpu_irq,
  output logic                    event_irq
);
  typedef struct packed {
    logic [7:0] enable_a;
    logic [7:0] enable_b;
    logic [7:0] int_ctrl;
    logic [7:0] evt_en;
    logic [1:0] cmp_sync1;
    logic [1:0] cmp_sync2;
    logic [1:0] cmp_prev;
    logic [2:0] cmp_valid;
    logic [31:0] rdata;
  } irq_state_t;

  irq_state_t st_r;
  irq_state_t st_nxt;

  logic       wr_acc;
  logic       rd_acc;
  logic       addr_ok;
  logic [7:0] wbyte;
  logic [7:0] set_a;
  logic [7:0] set_b;
  logic [7:0] clr_a;
  logic [7:0] clr_b;
  logic [7:0] flags_a;
  logic [7:0] flags_b;
  logic [7:0] evt_set;
  logic [7:0] evt_clr;
  logic [7:0] evt_stat;
  logic [1:0] cmp_change;
  logic       pend_a;
  logic       pend_b;

  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && !penable && !pwrite;
  assign wbyte  = pwdata[7:0];
  assign addr_ok = (paddr == OFF_ENABLE_A) || (paddr == OFF_ENABLE_B) ||
                   (paddr == OFF_FLAGS_A) || (paddr == OFF_FLAGS_B) ||
                   (paddr == OFF_INT_CTRL) || (paddr == OFF_EVT_STAT) ||
                   (paddr == OFF_EVT_EN) || (paddr == OFF_EVT_CLR);

  // comparator outputs are asynchronous: two stages, then compare to last
  // no edge until prev holds a real sample, else a high pin fakes one after reset
  assign cmp_change = st_r.cmp_valid[2] ? (st_r.cmp_sync2 ^ st_r.cmp_prev) : 2'b00;

  // flag sources, independent of any enable
  always_comb begin
    set_a = '0;
    set_b = '0;
    set_a[BIT_T1_GATE]   = timer1_gate_evt;
    set_a[BIT_CONV_DONE] = conversion_done_evt;
    set_a[BIT_LIMIT_TMR] = limit_timer_match_evt;
    set_a[BIT_TIMER2]    = timer2_match_evt;
    set_a[BIT_TIMER1]    = timer1_rollover_evt;
    set_b[BIT_CMP2]      = cmp_change[1];
    set_b[BIT_CMP1]      = cmp_change[0];
    set_b[BIT_WAVE_GEN]  = waveform_gen_shutdown_evt;
    set_b[BIT_CAP_CMP]   = ((ccp_mode == CCP_CAPTURE) && ccp_capture_evt) ||
                           ((ccp_mode == CCP_COMPARE) && ccp_compare_evt);
  end

  // software clears a flag by writing it to zero
  assign clr_a = (wr_acc && paddr == OFF_FLAGS_A) ? ~wbyte : '0;
  assign clr_b = (wr_acc && paddr == OFF_FLAGS_B) ? ~wbyte : '0;

  flag_bank #(.W(DATA_W)) u_flags_a (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .set_evt   (set_a),
    .clr       (clr_a),
    .impl_mask (MASK_A),
    .flags     (flags_a)
  );

  flag_bank #(.W(DATA_W)) u_flags_b (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .set_evt   (set_b),
    .clr       (clr_b),
    .impl_mask (MASK_B),
    .flags     (flags_b)
  );

  // request: any flag with its enable, gated by group enable; cpu_irq also by global enable
  assign pend_a = |(flags_a & st_r.enable_a);
  assign pend_b = |(flags_b & st_r.enable_b);
  assign periph_irq_req = (pend_a || pend_b) && st_r.int_ctrl[BIT_GROUP_EN];
  assign cpu_irq = periph_irq_req && st_r.int_ctrl[BIT_GLOBAL_EN];

  // event status: newly raised flags of either bank, sticky
  assign evt_set  = {6'h00, |(set_b & MASK_B), |(set_a & MASK_A)};
  assign evt_clr  = (wr_acc && paddr == OFF_EVT_CLR) ? wbyte : '0;

  flag_bank #(.W(DATA_W)) u_evt (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .set_evt   (evt_set),
    .clr       (evt_clr),
    .impl_mask (MASK_EVT),
    .flags     (evt_stat)
  );

  assign event_irq = |(evt_stat & st_r.evt_en);

  always_comb begin
    st_nxt = st_r;
    st_nxt.cmp_sync1 = {comparator2_output, comparator1_output};
    st_nxt.cmp_sync2 = st_r.cmp_sync1;
    st_nxt.cmp_prev  = st_r.cmp_sync2;
    st_nxt.cmp_valid = {st_r.cmp_valid[1:0], 1'b1};
    if (wr_acc) begin
      unique case (paddr)
        OFF_ENABLE_A: st_nxt.enable_a = wbyte & MASK_A;
        OFF_ENABLE_B: st_nxt.enable_b = wbyte & MASK_B;
        OFF_INT_CTRL: st_nxt.int_ctrl = wbyte & MASK_CTRL;
        OFF_EVT_EN:   st_nxt.evt_en   = wbyte & MASK_EVT;
        default:      st_nxt.int_ctrl = st_r.int_ctrl;
      endcase
    end
    if (rd_acc) begin
      unique case (paddr)
        OFF_ENABLE_A: st_nxt.rdata = {24'h000000, st_r.enable_a};
        OFF_ENABLE_B: st_nxt.rdata = {24'h000000, st_r.enable_b};
        OFF_FLAGS_A:  st_nxt.rdata = {24'h000000, flags_a};
        OFF_FLAGS_B:  st_nxt.rdata = {24'h000000, flags_b};
        OFF_INT_CTRL: st_nxt.rdata = {24'h000000, st_r.int_ctrl};
        OFF_EVT_STAT: st_nxt.rdata = {24'h000000, evt_stat};
        OFF_EVT_EN:   st_nxt.rdata = {24'h000000, st_r.evt_en};
        default:      st_nxt.rdata = READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata  = st_r.rdata;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  // assertions
  a_group_gate: assert property (@(posedge ref_clk) disable iff (rst)
    !st_r.int_ctrl[BIT_GROUP_EN] |-> !periph_irq_req && !cpu_irq)
    else $error("request without group enable");

  a_gate_enable: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r.int_ctrl[BIT_GROUP_EN] && flags_a[BIT_T1_GATE] && st_r.enable_a[BIT_T1_GATE])
    |-> periph_irq_req)
    else $error("gate request missing");

  a_conv_block: assert property (@(posedge ref_clk) disable iff (rst)
    (flags_a == (8'h01 << BIT_CONV_DONE) && flags_b == 8'h00 && !st_r.enable_a[BIT_CONV_DONE])
    |-> !periph_irq_req)
    else $error("disabled conversion request leaked");

  a_unimpl_zero: assert property (@(posedge ref_clk) disable iff (rst)
    ((st_r.enable_a & ~MASK_A) == 8'h00) && ((flags_a & ~MASK_A) == 8'h00))
    else $error("unimplemented bits set");

  a_b_unimpl: assert property (@(posedge ref_clk) disable iff (rst)
    ((st_r.enable_b & ~MASK_B) == 8'h00) && ((flags_b & ~MASK_B) == 8'h00))
    else $error("second register unimplemented bits set");

  a_flag_free: assert property (@(posedge ref_clk) disable iff (rst)
    timer2_match_evt |=> flags_a[BIT_TIMER2])
    else $error("flag not set without enable");

  sequence s_limit_set;
    limit_timer_match_evt ##1 (flags_a[BIT_LIMIT_TMR] && !clr_a[BIT_LIMIT_TMR]);
  endsequence

  a_limit_sticky: assert property (@(posedge ref_clk) disable iff (rst)
    s_limit_set |=> flags_a[BIT_LIMIT_TMR])
    else $error("limit flag lost without clear");

  a_roll_clear: assert property (@(posedge ref_clk) disable iff (rst)
    (clr_a[BIT_TIMER1] && !timer1_rollover_evt) |=> !flags_a[BIT_TIMER1])
    else $error("rollover flag not cleared");

  a_cmp_change: assert property (@(posedge ref_clk) disable iff (rst)
    cmp_change[1] |=> flags_b[BIT_CMP2])
    else $error("comparator change missed");

  a_pwm_unused: assert property (@(posedge ref_clk) disable iff (rst)
    (ccp_mode == CCP_PWM) |-> !set_b[BIT_CAP_CMP])
    else $error("pwm mode set capture flag");

  a_limit_gate: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r.int_ctrl[BIT_GROUP_EN] && flags_a[BIT_LIMIT_TMR] && st_r.enable_a[BIT_LIMIT_TMR])
    |-> periph_irq_req)
    else $error("limit timer request missing");

  a_timer2_gate: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r.int_ctrl[BIT_GROUP_EN] && flags_a[BIT_TIMER2] && st_r.enable_a[BIT_TIMER2])
    |-> periph_irq_req)
    else $error("timer2 request missing");

  a_gate_flag: assert property (@(posedge ref_clk) disable iff (rst)
    timer1_gate_evt |=> flags_a[BIT_T1_GATE])
    else $error("gate event not pending");

  a_conv_flag: assert property (@(posedge ref_clk) disable iff (rst)
    conversion_done_evt |=> flags_a[BIT_CONV_DONE])
    else $error("conversion done flag missed");

  a_t2_sticky: assert property (@(posedge ref_clk) disable iff (rst)
    (flags_a[BIT_TIMER2] && !clr_a[BIT_TIMER2]) |=> flags_a[BIT_TIMER2])
    else $error("timer2 flag lost without clear");

  a_t2_clear: assert property (@(posedge ref_clk) disable iff (rst)
    (clr_a[BIT_TIMER2] && !timer2_match_evt) |=> !flags_a[BIT_TIMER2])
    else $error("timer2 flag not cleared");

  a_shutdown_flag: assert property (@(posedge ref_clk) disable iff (rst)
    waveform_gen_shutdown_evt |=> flags_b[BIT_WAVE_GEN])
    else $error("shutdown flag missed");

  sequence s_capture_hit;
    (ccp_mode == CCP_CAPTURE) && ccp_capture_evt;
  endsequence

  a_capture_flag: assert property (@(posedge ref_clk) disable iff (rst)
    s_capture_hit |=> flags_b[BIT_CAP_CMP])
    else $error("capture flag missed");

  a_cmp1_change: assert property (@(posedge ref_clk) disable iff (rst)
    cmp_change[0] |=> flags_b[BIT_CMP1])
    else $error("comparator 1 change missed");

  a_cpu_gate: assert property (@(posedge ref_clk) disable iff (rst)
    cpu_irq |-> (periph_irq_req && st_r.int_ctrl[BIT_GLOBAL_EN]))
    else $error("cpu request without global enable");

  a_req_source: assert property (@(posedge ref_clk) disable iff (rst)
    periph_irq_req |-> (((flags_a & st_r.enable_a) | (flags_b & st_r.enable_b)) != 8'h00))
    else $error("request without enabled flag");

  sequence s_write_a;
    wr_acc && (paddr == OFF_ENABLE_A);
  endsequence

  a_enable_a_write: assert property (@(posedge ref_clk) disable iff (rst)
    s_write_a |=> (st_r.enable_a == $past(wbyte & MASK_A)))
    else $error("first enable register write lost");

  sequence s_write_b;
    wr_acc && (paddr == OFF_ENABLE_B);
  endsequence

  a_enable_b_write: assert property (@(posedge ref_clk) disable iff (rst)
    s_write_b |=> (st_r.enable_b == $past(wbyte & MASK_B)))
    else $error("second enable register write lost");
endmodule

// ===== verif/evt_src.sv
// event source model: one-cycle peripheral event pulses, comparator levels
// assumes fire is driven by the bench right after ref_clk rising edges
`timescale 1ns/1ns
module evt_src (
  input  wire logic        ref_clk,
  input  wire logic [12:0] fire,
  output logic      [12:0] pulse,
  output logic             cmp1_lvl,
  output logic             cmp2_lvl
);
  initial begin
    pulse    = 13'h0000;
    cmp1_lvl = 1'b0;
    cmp2_lvl = 1'b0;
  end
  always @(posedge ref_clk) begin
    pulse    <= fire;
    cmp1_lvl <= cmp1_lvl ^ fire[11];
    cmp2_lvl <= cmp2_lvl ^ fire[12];
  end
endmodule

// ===== verif/periph_irq_tb.sv
// self-checking bench for the peripheral interrupt block
// assumes zero-wait apb slave and event pulses from evt_src
`timescale 1ns/1ns
module periph_irq_tb import pie_pkg::*;;
  logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  ccp_mode;
  logic [12:0] fire, pulse;
  logic        cmp1_lvl, cmp2_lvl, periph_irq_req, cpu_irq, event_irq;
  int          fails, checks_done, cycles;

  evt_src i_src (.ref_clk, .fire, .pulse, .cmp1_lvl, .cmp2_lvl);
  periph_irq i_dut (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .timer1_gate_evt(pulse[7]), .conversion_done_evt(pulse[6]),
    .limit_timer_match_evt(pulse[2]), .timer2_match_evt(pulse[1]),
    .timer1_rollover_evt(pulse[0]), .comparator2_output(cmp2_lvl),
    .comparator1_output(cmp1_lvl), .waveform_gen_shutdown_evt(pulse[8]), .ccp_mode,
    .ccp_capture_evt(pulse[9]), .ccp_compare_evt(pulse[10]), .periph_irq_req,
    .cpu_irq, .event_irq);

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic conclude();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      fails = fails + 1;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one apb transfer, entered and left just after a rising edge
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 8'h00);
    chk(rd, exp);
  endtask

  task automatic wrrd(input logic [7:0] a, input logic [7:0] d, input logic [31:0] exp);
    xfer(a, 1'b1, d);
    rdchk(a, exp);
  endtask

  task automatic kick(input logic [12:0] f);
    fire <= f;
    @(posedge ref_clk);
    fire <= 13'h0000;
    repeat (8) @(posedge ref_clk);
  endtask

  task automatic t_reset();
    rdchk(OFF_ENABLE_A, 32'h0);
    chk({31'h0, err}, 32'h0);
    rdchk(OFF_ENABLE_B, 32'h0);
    rdchk(OFF_FLAGS_A, 32'h0);
    rdchk(OFF_FLAGS_B, 32'h0);
    xfer(8'h20, 1'b1, 8'hff);
    chk({31'h0, err}, 32'h1);
    chk({31'h0, pready}, 32'h1);
    rdchk(8'h20, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_regs();
    wrrd(OFF_ENABLE_A, 8'hff, 32'hc7);
    wrrd(OFF_ENABLE_B, 8'hff, 32'h35);
    wrrd(OFF_INT_CTRL, 8'hff, 32'hc0);
    wrrd(OFF_ENABLE_A, 8'h00, 32'h0);
    wrrd(OFF_ENABLE_B, 8'h00, 32'h0);
    wrrd(OFF_INT_CTRL, 8'h00, 32'h0);
    wrrd(OFF_FLAGS_A, 8'hff, 32'h0);
    $display("test regs done");
  endtask

  task automatic t_flags();
    kick(13'h1bc7);
    chk({31'h0, periph_irq_req}, 32'h0);
    rdchk(OFF_FLAGS_A, 32'hc7);
    rdchk(OFF_FLAGS_B, 32'h35);
    wrrd(OFF_FLAGS_A, 8'hfb, 32'hc3);
    wrrd(OFF_FLAGS_A, 8'hfc, 32'hc0);
    wrrd(OFF_FLAGS_A, 8'h00, 32'h0);
    wrrd(OFF_FLAGS_B, 8'h00, 32'h0);
    ccp_mode <= CCP_PWM;
    kick(13'h0200);
    rdchk(OFF_FLAGS_B, 32'h0);
    ccp_mode <= CCP_COMPARE;
    kick(13'h0400);
    rdchk(OFF_FLAGS_B, 32'h01);
    $display("test flags done");
  endtask

  task automatic t_gate();
    int bits[5] = '{7, 6, 2, 1, 0};
    for (int k = 0; k < 5; k++) begin
      xfer(OFF_FLAGS_A, 1'b1, 8'h00);
      kick(13'h0001 << bits[k]);
      xfer(OFF_ENABLE_A, 1'b1, 8'h01 << bits[k]);
      chk({31'h0, periph_irq_req}, 32'h0);
      xfer(OFF_INT_CTRL, 1'b1, 8'h40);
      chk({31'h0, periph_irq_req}, 32'h1);
      chk({31'h0, cpu_irq}, 32'h0);
      xfer(OFF_INT_CTRL, 1'b1, 8'hc0);
      chk({31'h0, cpu_irq}, 32'h1);
      xfer(OFF_ENABLE_A, 1'b1, 8'hc7 & ~(8'h01 << bits[k]));
      chk({31'h0, periph_irq_req}, 32'h0);
      xfer(OFF_INT_CTRL, 1'b1, 8'h00);
      xfer(OFF_ENABLE_A, 1'b1, 8'h00);
    end
    xfer(OFF_FLAGS_B, 1'b1, 8'h00);
    kick(13'h0800);
    xfer(OFF_ENABLE_B, 1'b1, 8'h10);
    xfer(OFF_INT_CTRL, 1'b1, 8'h40);
    chk({31'h0, periph_irq_req}, 32'h1);
    xfer(OFF_INT_CTRL, 1'b1, 8'h00);
    $display("test gate done");
  endtask

  task automatic t_evt();
    xfer(OFF_EVT_CLR, 1'b1, 8'h03);
    kick(13'h0002);
    rdchk(OFF_EVT_STAT, 32'h1);
    chk({31'h0, event_irq}, 32'h0);
    xfer(OFF_EVT_EN, 1'b1, 8'h01);
    chk({31'h0, event_irq}, 32'h1);
    xfer(OFF_EVT_CLR, 1'b1, 8'h01);
    chk({31'h0, event_irq}, 32'h0);
    rdchk(OFF_EVT_STAT, 32'h0);
    rdchk(OFF_EVT_CLR, 32'h0);
    $display("test event irq done");
  endtask

  // reset in mid-run with comparator 2 pin left high
  task automatic t_rerst();
    xfer(OFF_ENABLE_A, 1'b1, 8'hc7);
    xfer(OFF_INT_CTRL, 1'b1, 8'hc0);
    chk({31'h0, cpu_irq}, 32'h1);
    rst <= 1'b1;
    @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    chk({31'h0, cpu_irq}, 32'h0);
    rdchk(OFF_ENABLE_A, 32'h0);
    rdchk(OFF_INT_CTRL, 32'h0);
    rdchk(OFF_FLAGS_A, 32'h0);
    rdchk(OFF_FLAGS_B, 32'h0);
    $display("test mid-run reset done");
  endtask

  initial begin
    rst         = 1'b1;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 8'h00;
    pwdata      = 32'h0;
    fire        = 13'h0000;
    ccp_mode    = CCP_CAPTURE;
    fails       = 0;
    checks_done = 0;
    cycles      = 0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_regs();
    t_flags();
    t_gate();
    t_evt();
    t_rerst();
    conclude();
  end
endmodule
